// ### opsr_top.sv
// File: display driver reset state, serial shift register and sequencer
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module opsr_top (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic panel_reset_low,
   input wire logic [opsr_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic ser_clk,
   input wire logic ser_data,
   output logic display_on,
   output logic entire_on,
   output logic seg_remap,
   output logic scan_reverse,
   output logic [5:0] mux_ratio,
   output logic [5:0] start_line,
   output logic [7:0] contrast,
   output logic [6:0] column_addr,
   output logic in_reset
);
   import opsr_pkg::*;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [1:0] prst_sync_reg;
   logic [1:0] sclk_sync_reg;
   logic [1:0] sdat_sync_reg;
   logic sclk_last_reg;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         prst_sync_reg <= 2'b00;
         sclk_sync_reg <= 2'b00;
         sdat_sync_reg <= 2'b00;
         sclk_last_reg <= 1'b0;
      end else begin
         prst_sync_reg <= {prst_sync_reg[0], panel_reset_low};
         sclk_sync_reg <= {sclk_sync_reg[0], ser_clk};
         sdat_sync_reg <= {sdat_sync_reg[0], ser_data};
         sclk_last_reg <= sclk_sync_reg[1];
      end
   end

   wire panel_rst = ~prst_sync_reg[1];
   wire sclk_rise = sclk_sync_reg[1] & ~sclk_last_reg;

   // ----------------------------------------------------------------
   // Wake sequencer after panel reset release
   // ----------------------------------------------------------------
   opsr_state_t state_reg;
   opsr_state_t state_next;
   logic [7:0] wake_cnt_reg;
   logic [7:0] wake_cnt_next;

   wire wake_done = (wake_cnt_reg == 8'(WAKE_CYCLES - 1));

   always_comb begin
      state_next = state_reg;
      wake_cnt_next = wake_cnt_reg;
      case (state_reg)
         OPSR_ST_RESET: begin
            wake_cnt_next = 8'h00;
            if (!panel_rst) begin
               state_next = OPSR_ST_WAKE;
            end
         end
         OPSR_ST_WAKE: begin
            wake_cnt_next = wake_cnt_reg + 8'h01;
            if (wake_done) begin
               state_next = OPSR_ST_RUN;
            end
         end
         OPSR_ST_RUN: begin
            wake_cnt_next = 8'h00;
         end
         default: begin
            state_next = OPSR_ST_RESET;
            wake_cnt_next = 8'h00;
         end
      endcase
      if (panel_rst) begin
         state_next = OPSR_ST_RESET;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= OPSR_ST_RESET;
         wake_cnt_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         wake_cnt_reg <= wake_cnt_next;
      end
   end

   wire running = (state_reg == OPSR_ST_RUN);

   // ----------------------------------------------------------------
   // Serial shift register: MSB first, a full byte becomes a command
   // ----------------------------------------------------------------
   logic [7:0] shift_reg;
   logic [2:0] bit_cnt_reg;
   wire [7:0] shift_next = {shift_reg[6:0], sdat_sync_reg[1]};
   wire ser_byte = running & sclk_rise & (bit_cnt_reg == 3'h7);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         shift_reg <= RST_SHIFT;
         bit_cnt_reg <= RST_BIT_CNT;
      end else if (panel_rst) begin
         shift_reg <= RST_SHIFT;
         bit_cnt_reg <= RST_BIT_CNT;
      end else if (running && sclk_rise) begin
         shift_reg <= shift_next;
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // Register port decode
   // ----------------------------------------------------------------
   opsr_bus_t bus;
   assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   function automatic logic hit(input opsr_bus_t b, input logic [3:0] a);
      hit = b.wr & (b.addr == a);
   endfunction : hit

   wire wr_cmd = running & hit(bus, ADDR_CMD);
   wire wr_contrast = running & hit(bus, ADDR_CONTRAST);
   wire wr_start = running & hit(bus, ADDR_START);
   wire wr_column = running & hit(bus, ADDR_COLUMN);
   wire wr_mode = running & hit(bus, ADDR_MODE);
   wire wr_gaddr = running & hit(bus, ADDR_GRAM_ADDR);
   wire wr_gdata = running & hit(bus, ADDR_GRAM_DATA);

   // Command from register port wins over a serial byte in the same cycle
   wire cmd_valid = wr_cmd | ser_byte;
   wire [7:0] cmd_code = wr_cmd ? bus.wdata : shift_next;

   // ----------------------------------------------------------------
   // Configuration state
   // ----------------------------------------------------------------
   opsr_cfg_t cfg_reg;
   opsr_cfg_t cfg_next;
   localparam opsr_cfg_t CFG_RESET = '{
      display_on: 1'b0,
      entire_on: 1'b0,
      seg_remap: 1'b0,
      scan_reverse: 1'b0,
      mux_ratio: RST_MUX_RATIO,
      start_line: RST_START_LINE,
      contrast: RST_CONTRAST
   };

   always_comb begin
      cfg_next = cfg_reg;
      if (cmd_valid) begin
         case (cmd_code)
            CMD_DISPLAY_OFF: cfg_next.display_on = 1'b0;
            CMD_DISPLAY_ON: cfg_next.display_on = 1'b1;
            CMD_NORMAL_DISPLAY: cfg_next.entire_on = 1'b0;
            CMD_ENTIRE_ON: cfg_next.entire_on = 1'b1;
            CMD_SEG_NORMAL: cfg_next.seg_remap = 1'b0;
            CMD_SEG_REMAP: cfg_next.seg_remap = 1'b1;
            CMD_SCAN_NORMAL: cfg_next.scan_reverse = 1'b0;
            CMD_SCAN_REVERSE: cfg_next.scan_reverse = 1'b1;
            default: cfg_next = cfg_reg;
         endcase
      end
      if (wr_contrast) begin
         cfg_next.contrast = bus.wdata;
      end
      if (wr_start) begin
         cfg_next.start_line = bus.wdata[5:0];
      end
      if (wr_mode) begin
         cfg_next.mux_ratio = bus.wdata[5:0];
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cfg_reg <= CFG_RESET;
      end else if (panel_rst) begin
         // Display off, 128x64, unremapped, normal scan, 7Fh, A4h mode
         cfg_reg <= CFG_RESET;
      end else begin
         cfg_reg <= cfg_next;
      end
   end

   // ----------------------------------------------------------------
   // Column address counter and display memory
   // ----------------------------------------------------------------
   logic [6:0] column_reg;
   logic [2:0] page_reg;
   logic [7:0] gram_rdata;
   wire [6:0] column_inc = (column_reg == COLUMN_LAST) ? RST_COLUMN
                                                       : column_reg + 7'h01;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         column_reg <= RST_COLUMN;
         page_reg <= 3'h0;
      end else if (panel_rst) begin
         column_reg <= RST_COLUMN;
         page_reg <= 3'h0;
      end else if (wr_column) begin
         column_reg <= bus.wdata[6:0];
      end else if (wr_gaddr) begin
         page_reg <= bus.wdata[2:0];
      end else if (wr_gdata) begin
         column_reg <= column_inc;
      end
   end

   opsr_gram u_gram (
      .clk_sys(clk_sys),
      .we(wr_gdata),
      .waddr({page_reg, column_reg}),
      .wdata(bus.wdata),
      .raddr({page_reg, column_reg}),
      .rdata(gram_rdata)
   );

   // ----------------------------------------------------------------
   // Read data mux
   // ----------------------------------------------------------------
   logic [7:0] status_word;
   always_comb begin
      status_word = 8'h00;
      status_word[ST_DISPLAY_ON] = cfg_reg.display_on;
      status_word[ST_ENTIRE_ON] = cfg_reg.entire_on;
      status_word[ST_SEG_REMAP] = cfg_reg.seg_remap;
      status_word[ST_SCAN_REV] = cfg_reg.scan_reverse;
      status_word[ST_IN_RESET] = ~running;
   end

   logic [7:0] rd_sel;
   always_comb begin
      case (bus.addr)
         ADDR_STATUS: rd_sel = status_word;
         ADDR_CONTRAST: rd_sel = cfg_reg.contrast;
         ADDR_START: rd_sel = {2'b00, cfg_reg.start_line};
         ADDR_COLUMN: rd_sel = {1'b0, column_reg};
         ADDR_MODE: rd_sel = {2'b00, cfg_reg.mux_ratio};
         ADDR_SHIFT: rd_sel = shift_reg;
         ADDR_GRAM_ADDR: rd_sel = {5'h00, page_reg};
         ADDR_GRAM_DATA: rd_sel = gram_rdata;
         default: rd_sel = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
         display_on <= 1'b0;
         entire_on <= 1'b0;
         seg_remap <= 1'b0;
         scan_reverse <= 1'b0;
         mux_ratio <= RST_MUX_RATIO;
         start_line <= RST_START_LINE;
         contrast <= RST_CONTRAST;
         column_addr <= RST_COLUMN;
         in_reset <= 1'b1;
      end else begin
         reg_rdata <= bus.rd ? rd_sel : 8'h00;
         display_on <= cfg_reg.display_on;
         entire_on <= cfg_reg.entire_on;
         seg_remap <= cfg_reg.seg_remap;
         scan_reverse <= cfg_reg.scan_reverse;
         mux_ratio <= cfg_reg.mux_ratio;
         start_line <= cfg_reg.start_line;
         contrast <= cfg_reg.contrast;
         column_addr <= column_reg;
         in_reset <= ~running;
      end
   end

endmodule : opsr_top
`default_nettype wire

// ### opsr_pkg.sv
// Package: constants and types for the display power/reset sequencer
package opsr_pkg;

   // ----------------------------------------------------------------
   // Register map (word addresses on the plain register port)
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 4;
   localparam logic [3:0] ADDR_CMD = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_CONTRAST = 4'h2;
   localparam logic [3:0] ADDR_START = 4'h3;
   localparam logic [3:0] ADDR_COLUMN = 4'h4;
   localparam logic [3:0] ADDR_MODE = 4'h5;
   localparam logic [3:0] ADDR_SHIFT = 4'h6;
   localparam logic [3:0] ADDR_GRAM_ADDR = 4'h7;
   localparam logic [3:0] ADDR_GRAM_DATA = 4'h8;

   // ----------------------------------------------------------------
   // Command codes written to ADDR_CMD
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_DISPLAY_OFF = 8'hAE;
   localparam logic [7:0] CMD_DISPLAY_ON = 8'hAF;
   localparam logic [7:0] CMD_NORMAL_DISPLAY = 8'hA4;
   localparam logic [7:0] CMD_ENTIRE_ON = 8'hA5;
   localparam logic [7:0] CMD_SEG_NORMAL = 8'hA0;
   localparam logic [7:0] CMD_SEG_REMAP = 8'hA1;
   localparam logic [7:0] CMD_SCAN_NORMAL = 8'hC0;
   localparam logic [7:0] CMD_SCAN_REVERSE = 8'hC8;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_CONTRAST = 8'h7F;
   localparam logic [5:0] RST_START_LINE = 6'h00;
   localparam logic [6:0] RST_COLUMN = 7'h00;
   localparam logic [5:0] RST_MUX_RATIO = 6'h3F;
   localparam logic [7:0] RST_SHIFT = 8'h00;
   localparam logic [2:0] RST_BIT_CNT = 3'h0;

   // ----------------------------------------------------------------
   // Status word field positions
   // ----------------------------------------------------------------
   localparam int unsigned ST_DISPLAY_ON = 0;
   localparam int unsigned ST_ENTIRE_ON = 1;
   localparam int unsigned ST_SEG_REMAP = 2;
   localparam int unsigned ST_SCAN_REV = 3;
   localparam int unsigned ST_IN_RESET = 4;

   // ----------------------------------------------------------------
   // Geometry and timing
   // ----------------------------------------------------------------
   localparam int unsigned COLUMNS = 128;
   localparam logic [6:0] COLUMN_LAST = 7'h7F;
   localparam int unsigned GRAM_AW = 10;
   localparam int unsigned GRAM_DEPTH = 1024;
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned WAKE_NS = 200;
   localparam int unsigned WAKE_CYCLES = (WAKE_NS * CLK_MHZ + 999) / 1000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      OPSR_ST_RESET = 2'b00,
      OPSR_ST_WAKE = 2'b01,
      OPSR_ST_RUN = 2'b10
   } opsr_state_t;

   typedef struct packed {
      logic display_on;
      logic entire_on;
      logic seg_remap;
      logic scan_reverse;
      logic [5:0] mux_ratio;
      logic [5:0] start_line;
      logic [7:0] contrast;
   } opsr_cfg_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } opsr_bus_t;

endpackage : opsr_pkg

// ### opsr_gram.sv
// File: display memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module opsr_gram (
   input wire logic clk_sys,
   input wire logic we,
   input wire logic [opsr_pkg::GRAM_AW-1:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [opsr_pkg::GRAM_AW-1:0] raddr,
   output logic [7:0] rdata
);
   import opsr_pkg::*;

   logic [7:0] mem [GRAM_DEPTH];

   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end

endmodule : opsr_gram
`default_nettype wire

// ### opsr_top_checker.sv
// Checker: reset state and reset entry of the display driver outputs
`timescale 1ns/1ps
`default_nettype none
module opsr_top_checker (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic panel_reset_low,
   input wire logic [opsr_pkg::ADDR_W-1:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic display_on,
   input wire logic entire_on,
   input wire logic seg_remap,
   input wire logic scan_reverse,
   input wire logic [5:0] mux_ratio,
   input wire logic [5:0] start_line,
   input wire logic [7:0] contrast,
   input wire logic [6:0] column_addr,
   input wire logic in_reset
);
   import opsr_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // ------------------------------------------------------------
   // Reset held for two edges
   // ------------------------------------------------------------
   sequence held_s;
      in_reset ##1 in_reset;
   endsequence
   rst_entry_a: assert property ($fell(panel_reset_low) |-> ##[1:4] in_reset)
      else $error("reset not entered after pin low");
   rst_display_off_a: assert property (held_s |-> !display_on && mux_ratio == 6'h3F)
      else $error("display not off or mux wrong in reset");
   rst_seg_map_a: assert property (held_s |-> !seg_remap)
      else $error("segment mapping not normal in reset");
   shift_cleared_a: assert property (held_s ##0 (reg_rd && reg_addr == ADDR_SHIFT) |=> reg_rdata == 8'h00)
      else $error("shift register not cleared in reset");
   rst_start_line_a: assert property (held_s |-> start_line == 6'h00)
      else $error("start line not zero in reset");
   rst_column_a: assert property (held_s |-> column_addr == 7'h00)
      else $error("column counter not zero in reset");
   rst_scan_dir_a: assert property (held_s |-> !scan_reverse)
      else $error("scan direction not normal in reset");
   rst_contrast_a: assert property (held_s |-> contrast == 8'h7F)
      else $error("contrast not default in reset");
   rst_normal_disp_a: assert property (held_s |-> !entire_on)
      else $error("display mode not normal in reset");
   cover property (held_s ##1 !in_reset);
   cover property ($rose(display_on));
   cover property (in_reset && reg_rd && reg_addr == ADDR_SHIFT);
endmodule : opsr_top_checker

bind opsr_top opsr_top_checker chk_u (.clk_sys(clk_sys), .reset_n(reset_n),
   .panel_reset_low(panel_reset_low), .reg_addr(reg_addr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .display_on(display_on), .entire_on(entire_on),
   .seg_remap(seg_remap), .scan_reverse(scan_reverse),
   .mux_ratio(mux_ratio), .start_line(start_line), .contrast(contrast),
   .column_addr(column_addr), .in_reset(in_reset));
`default_nettype wire

// ### opsr_host.sv
// Host model: register port, serial pins, panel reset and supply order
`timescale 1ns/1ps
`default_nettype none
module opsr_host #(
   parameter int STABLE_WAIT = 12_500_000
) (
   input wire logic clk_sys,
   input wire logic [7:0] reg_rdata,
   output logic panel_reset_low,
   output logic [opsr_pkg::ADDR_W-1:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic ser_clk,
   output logic ser_data
);
   import opsr_pkg::*;
   logic logic_supply;
   logic panel_supply;
   initial begin
      {panel_reset_low, reg_wr, reg_rd, ser_clk, ser_data} = 5'h10;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      logic_supply = 1'b0;
      panel_supply = 1'b0;
   end
   // ------------------------------------------------------------
   // Bus and pin tasks; each returns only once its transfer is over
   // ------------------------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      d = reg_rdata;
   endtask : rd
   task automatic ser_bits(input logic [7:0] b, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         @(posedge clk_sys);
         ser_data <= b[i];
         repeat (4) @(posedge clk_sys);
         ser_clk <= 1'b1;
         repeat (4) @(posedge clk_sys);
         ser_clk <= 1'b0;
      end
      ser_data <= ~b[8 - n];
      repeat (6) @(posedge clk_sys);
   endtask : ser_bits
   task automatic panel_hold(input logic v);
      @(posedge clk_sys);
      panel_reset_low <= v;
   endtask : panel_hold
   task automatic power_up();
      logic_supply = 1'b1;
      wr(ADDR_CMD, CMD_DISPLAY_OFF);
      wr(ADDR_CONTRAST, 8'hC3);
      for (int c = 0; c < 4; c++) wr(ADDR_GRAM_DATA, 8'h00);
      panel_supply = 1'b1;
      repeat (STABLE_WAIT) @(posedge clk_sys);
      wr(ADDR_CMD, CMD_DISPLAY_ON);
   endtask : power_up
   task automatic power_down();
      wr(ADDR_CMD, CMD_DISPLAY_OFF);
      panel_supply = 1'b0;
      repeat (STABLE_WAIT) @(posedge clk_sys);
      logic_supply = 1'b0;
   endtask : power_down
endmodule : opsr_host
`default_nettype wire

// ### opsr_top_bench.sv
// Self-checking bench for the display reset state and host sequencing
`timescale 1ns/1ps
`default_nettype none
module opsr_top_bench;
   import opsr_pkg::*;
   logic clk_sys, reset_n, panel_reset_low, reg_wr, reg_rd;
   logic ser_clk, ser_data, display_on, entire_on, seg_remap;
   logic scan_reverse, in_reset;
   logic [ADDR_W-1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, contrast, rd_val;
   logic [5:0] mux_ratio, start_line;
   logic [6:0] column_addr;
   int fails = 0;
   int cmp_count = 0;
   opsr_top dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
      .panel_reset_low(panel_reset_low), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ser_clk(ser_clk), .ser_data(ser_data),
      .display_on(display_on), .entire_on(entire_on),
      .seg_remap(seg_remap), .scan_reverse(scan_reverse),
      .mux_ratio(mux_ratio), .start_line(start_line),
      .contrast(contrast), .column_addr(column_addr), .in_reset(in_reset));
   opsr_host #(.STABLE_WAIT(20)) host_u (.clk_sys(clk_sys),
      .reg_rdata(reg_rdata), .panel_reset_low(panel_reset_low),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .ser_clk(ser_clk), .ser_data(ser_data));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // ------------------------------------------------------------
   // Compare, reset-state and closing tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic chk_rst();
      chk({7'h0, display_on}, 8'h00, "display_on");
      chk({2'h0, mux_ratio}, 8'h3F, "mux_ratio");
      chk({7'h0, seg_remap}, 8'h00, "seg_remap");
      chk({2'h0, start_line}, 8'h00, "start_line");
      chk({1'h0, column_addr}, 8'h00, "column_addr");
      chk({7'h0, scan_reverse}, 8'h00, "scan_reverse");
      chk(contrast, 8'h7F, "contrast");
      chk({7'h0, entire_on}, 8'h00, "entire_on");
   endtask : chk_rst
   task automatic wait_ready();
      int n;
      n = 0;
      while (in_reset !== 1'b0 && n < 200) begin
         @(posedge clk_sys);
         n++;
      end
      chk({7'h0, in_reset}, 8'h00, "in_reset released");
      @(posedge clk_sys);
   endtask : wait_ready
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (5000) @(posedge clk_sys);
      fails++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      report_and_stop();
   end
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 chk_rst();
      @(posedge clk_sys);
      reset_n <= 1'b1;
      wait_ready();
      chk_rst();
      $display("test reset_defaults done");
      host_u.power_up();
      repeat (2) @(posedge clk_sys);
      chk({7'h0, display_on}, 8'h01, "display on");
      chk(contrast, 8'hC3, "contrast set");
      chk({1'h0, column_addr}, 8'h04, "column after clear");
      host_u.wr(ADDR_GRAM_DATA, 8'h5A);
      host_u.wr(ADDR_COLUMN, 8'h04);
      host_u.rd(ADDR_GRAM_DATA, rd_val);
      chk(rd_val, 8'h5A, "memory readback");
      $display("test power_up done");
      host_u.wr(ADDR_START, 8'h2A);
      host_u.wr(ADDR_COLUMN, 8'h7F);
      host_u.wr(ADDR_MODE, 8'h1F);
      host_u.wr(ADDR_CMD, CMD_SEG_REMAP);
      host_u.wr(ADDR_CMD, CMD_SCAN_REVERSE);
      host_u.wr(ADDR_CMD, CMD_ENTIRE_ON);
      host_u.ser_bits(8'hFF, 3);
      host_u.rd(ADDR_STATUS, rd_val);
      chk(rd_val, 8'h0F, "status before reset");
      chk({2'h0, start_line}, 8'h2A, "start line set");
      chk({2'h0, mux_ratio}, 8'h1F, "mux set");
      chk({1'h0, column_addr}, 8'h7F, "column set");
      host_u.panel_hold(1'b0);
      repeat (6) @(posedge clk_sys);
      host_u.wr(ADDR_CONTRAST, 8'h11);
      host_u.rd(ADDR_SHIFT, rd_val);
      chk(rd_val, 8'h00, "shift cleared");
      chk_rst();
      host_u.panel_hold(1'b1);
      wait_ready();
      chk_rst();
      $display("test panel_reset done");
      host_u.ser_bits(CMD_DISPLAY_ON, 8);
      chk({7'h0, display_on}, 8'h01, "serial display on");
      host_u.rd(4'hF, rd_val);
      chk(rd_val, 8'h00, "unmapped read");
      $display("test serial_after_reset done");
      host_u.power_down();
      chk({7'h0, display_on}, 8'h00, "power down off");
      $display("test power_down done");
      report_and_stop();
   end
endmodule : opsr_top_bench
`default_nettype wire
